// ### rtl/pmfc_pkg.sv
// Constants, field layout and helpers for the power and fill-count registers
package pmfc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_PWR_MAIN = 7'h6b;
  localparam logic [ADDR_W-1:0] ADDR_AXIS     = 7'h6c;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL   = 7'h70;
  localparam logic [ADDR_W-1:0] ADDR_FILL_HI  = 7'h72;
  localparam logic [ADDR_W-1:0] ADDR_FILL_LO  = 7'h73;

  // power_control_main fields
  localparam int BIT_DEV_RESET = 7;
  localparam int BIT_HALT      = 6;
  localparam int BIT_CYCLE     = 5;
  localparam int BIT_GYRO_STBY = 4;
  localparam int BIT_THERM_OFF = 3;
  localparam int CLOCK_SOURCE_SELECT_LSB    = 0;
  localparam int CLOCK_SOURCE_SELECT_W      = 3;

  // axis_standby_control fields, X in the top bit of each group
  localparam int ACCEL_LSB = 3;
  localparam int RATE_LSB  = 0;
  localparam int AXIS_W    = 3;

  // serial_port_select field
  localparam int BIT_TWO_WIRE_OFF = 6;

  // Writable bits; everything else reads zero, except power_control_main bit 7, which reads soft reset busy
  localparam logic [DATA_W-1:0] PWR_MAIN_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] AXIS_MASK     = 8'h3f;
  localparam logic [DATA_W-1:0] SERIAL_MASK   = 8'h40;

  // Defaults
  localparam logic [DATA_W-1:0]   PWR_MAIN_DEF = 8'h01;
  localparam logic [DATA_W-1:0]   AXIS_DEF     = 8'h00;
  localparam logic [DATA_W-1:0]   SERIAL_DEF   = 8'h00;
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLOCK_SOURCE_SELECT_DEF   = 3'h1;
  localparam logic [DATA_W-1:0]   RDATA_NONE   = 8'h00;

  // Clock source codes
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLK_OSC_A   = 3'h0;
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLK_AUTO_LO = 3'h1;
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLK_AUTO_HI = 3'h5;
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLK_OSC_B   = 3'h6;
  localparam logic [CLOCK_SOURCE_SELECT_W-1:0] CLK_HALT    = 3'h7;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SOFT_RST_NS   = 100;
  localparam int SOFT_RST_CYC  =
    (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRST_CNT_W    = 4;
  localparam logic [SRST_CNT_W-1:0] SRST_LAST =
    SRST_CNT_W'(SOFT_RST_CYC - 1);
  localparam int WAKE_BASE_NS  = 1000000;
  localparam int WAKE_BASE_CYC_DEF = WAKE_BASE_NS / CLK_PERIOD_NS;
  localparam int BASE_CNT_W    = 17;
  localparam int FILL_W        = 16;

  typedef enum logic [1:0] {DC_IDLE, DC_DOZE, DC_WAKE} pmfc_duty_t;

  function automatic logic clk_is_osc(input logic [CLOCK_SOURCE_SELECT_W-1:0] code);
    return (code == CLK_OSC_A) || (code == CLK_OSC_B);
  endfunction : clk_is_osc

  function automatic logic clk_is_auto(input logic [CLOCK_SOURCE_SELECT_W-1:0] code);
    return (code >= CLK_AUTO_LO) && (code <= CLK_AUTO_HI);
  endfunction : clk_is_auto

endpackage : pmfc_pkg

// ### rtl/pmfc_fill_latch.sv
// Snapshot latch for the two fill-count bytes
`timescale 1ns/1ps
module pmfc_fill_latch
  import pmfc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clr_i,
  input  wire logic [FILL_W-1:0] live_i,
  input  wire logic              rd_hi_i,
  input  wire logic              rd_lo_i,
  output logic      [FILL_W-1:0] held_o,
  output logic                   armed_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_o <= '0;
    end else if (clr_i) begin
      held_o <= '0;
    end else if (armed_o && !rd_hi_i) begin
      held_o <= live_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_o <= 1'b1;
    end else if (clr_i || rd_lo_i) begin
      armed_o <= 1'b1;
    end else if (rd_hi_i) begin
      armed_o <= 1'b0;
    end
  end

endmodule : pmfc_fill_latch

// ### rtl/pmfc_duty_timer.sv
// Wake pacing for duty-cycled accelerometer sampling
`timescale 1ns/1ps
module pmfc_duty_timer
  import pmfc_pkg::*;
#(
  parameter int unsigned BASE_CYC = WAKE_BASE_CYC_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              run_i,
  input  wire logic [DATA_W-1:0] div_i,
  input  wire logic              accel_any_i,
  output logic                   wake_o,
  output logic                   sample_o
);

  pmfc_duty_t            state_r;
  logic [BASE_CNT_W-1:0] base_cnt_r;
  logic [DATA_W-1:0]     div_cnt_r;
  logic                  tick;
  logic                  due;

  assign tick = (base_cnt_r == BASE_CNT_W'(BASE_CYC - 1));
  assign due  = tick && (div_cnt_r == div_i);

  ////////////////////////////////////////////////////////////////////////
  // Divider paced wake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= DC_IDLE;
      base_cnt_r <= '0;
      div_cnt_r  <= '0;
    end else begin
      case (state_r)
        DC_IDLE: begin
          base_cnt_r <= '0;
          div_cnt_r  <= '0;
          if (run_i) begin
            state_r <= DC_DOZE;
          end
        end
        DC_DOZE: begin
          base_cnt_r <= tick ? '0 : base_cnt_r + 1'b1;
          if (tick) begin
            div_cnt_r <= due ? '0 : div_cnt_r + 1'b1;
          end
          if (!run_i) begin
            state_r <= DC_IDLE;
          end else if (due) begin
            state_r <= DC_WAKE;
          end
        end
        DC_WAKE: begin
          // Wake cycle counts toward the next base period, no drift
          base_cnt_r <= base_cnt_r + 1'b1;
          state_r <= run_i ? DC_DOZE : DC_IDLE;
        end
        default: begin
          state_r <= DC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_o   <= 1'b0;
      sample_o <= 1'b0;
    end else begin
      wake_o   <= (state_r == DC_DOZE) && due && run_i;
      sample_o <= (state_r == DC_DOZE) && due && run_i && accel_any_i;
    end
  end

endmodule : pmfc_duty_timer

// ### rtl/pmfc_regs.sv
// Power management, serial mode and fill-count register bank
//
// Function
// - Writing soft reset restores defaults; bit self-clears when done.
// - Halt bit set keeps device asleep.
// - Cycle bit alone alternates sleep and one paced accelerometer sample.
// - Cycle with all accelerometer axes off wakes but takes no sample.
// - Gyro standby keeps drive and PLL on, sense paths off.
// - Thermal off bit switches the temperature sensor off.
// - Clock codes 0 and 6 select internal oscillator.
// - Codes 1 to 5 use PLL when ready, else oscillator.
// - Code 7 stops clock and holds timing generator in reset.
// - Clock source field resets to 001.
// - Axis register bits 5..3 switch accelerometer X, Y, Z off.
// - Axis register bits 2..0 switch gyro X, Y, Z off.
// - Serial bit 6 turns off two-wire target, SPI only.
// - Fill count reported as 16 bits over high and low bytes.
// - High byte read snapshots count into both bytes.
`timescale 1ns/1ps
module pmfc_regs
  import pmfc_pkg::*;
#(
  parameter int unsigned WAKE_BASE_CYC = WAKE_BASE_CYC_DEF
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  input  wire logic [FILL_W-1:0] FILL_COUNT_I,
  input  wire logic [DATA_W-1:0] SAMPLE_RATE_DIVIDER_I,
  input  wire logic              PLL_READY_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  output logic                   REG_RVALID_O,
  output logic                   SOFT_RESET_BUSY_O,
  output logic                   DEVICE_SLEEP_O,
  output logic                   WAKE_O,
  output logic                   ACCEL_SAMPLE_O,
  output logic      [AXIS_W-1:0] ACCEL_AXIS_EN_O,
  output logic      [AXIS_W-1:0] RATE_SENSE_EN_O,
  output logic                   GYRO_DRIVE_EN_O,
  output logic                   PLL_EN_O,
  output logic                   THERMAL_SENSOR_EN_O,
  output logic                   CLK_USE_OSC_O,
  output logic                   CLK_USE_PLL_O,
  output logic                   CLK_STOP_O,
  output logic                   TIMING_RESET_O,
  output logic                   TWO_WIRE_TARGET_OFF_O
);

  logic [DATA_W-1:0]     power_control_main_r;
  logic [DATA_W-1:0]     axis_standby_control_r;
  logic [DATA_W-1:0]     serial_port_select_r;
  logic                  srst_r;
  logic [SRST_CNT_W-1:0] srst_cnt_r;
  logic                  pll_s1_r;
  logic                  pll_s2_r;
  logic                  pll_s3_r;
  logic                  pll_ok_r;
  logic [FILL_W-1:0]     fill_held;
  logic                  fill_armed;
  logic                  wr_main;
  logic                  rd_hi;
  logic                  rd_lo;
  logic [CLOCK_SOURCE_SELECT_W-1:0]   clock_source_select;
  logic                  halt;
  logic                  cycle_run;
  logic                  clk_halted;
  logic [AXIS_W-1:0]     accel_off;
  logic [AXIS_W-1:0]     rate_off;
  logic                  gyro_stby;
  logic [DATA_W-1:0]     rd_mux;

  assign wr_main = REG_WR_I && (REG_ADDR_I == ADDR_PWR_MAIN);
  assign rd_hi   = REG_RD_I && (REG_ADDR_I == ADDR_FILL_HI);
  assign rd_lo   = REG_RD_I && (REG_ADDR_I == ADDR_FILL_LO);

  assign clock_source_select =
    power_control_main_r[CLOCK_SOURCE_SELECT_LSB +: CLOCK_SOURCE_SELECT_W];
  assign halt       = power_control_main_r[BIT_HALT];
  assign gyro_stby  = power_control_main_r[BIT_GYRO_STBY];
  assign clk_halted = (clock_source_select == CLK_HALT);
  assign accel_off  = axis_standby_control_r[ACCEL_LSB +: AXIS_W];
  assign rate_off   = axis_standby_control_r[RATE_LSB +: AXIS_W];
  // Cycle only without halt or standby
  assign cycle_run  = power_control_main_r[BIT_CYCLE] && !halt &&
                      !gyro_stby && !clk_halted && !srst_r;

  ////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer; a fixed stretch lets every domain see it
  // Start and self-clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      srst_r     <= 1'b0;
      srst_cnt_r <= '0;
    end else if (srst_r) begin
      srst_cnt_r <= srst_cnt_r + 1'b1;
      if (srst_cnt_r == SRST_LAST) begin
        srst_r <= 1'b0;
      end
    end else if (wr_main && REG_WDATA_I[BIT_DEV_RESET]) begin
      srst_r     <= 1'b1;
      srst_cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers; writes during soft reset are dropped
  // Defaults on reset
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      power_control_main_r <= PWR_MAIN_DEF;
    end else if (srst_r) begin
      power_control_main_r <= PWR_MAIN_DEF;
    end else if (wr_main && !REG_WDATA_I[BIT_DEV_RESET]) begin
      power_control_main_r <= REG_WDATA_I & PWR_MAIN_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      axis_standby_control_r <= AXIS_DEF;
    end else if (srst_r) begin
      axis_standby_control_r <= AXIS_DEF;
    end else if (REG_WR_I && (REG_ADDR_I == ADDR_AXIS)) begin
      axis_standby_control_r <= REG_WDATA_I & AXIS_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      serial_port_select_r <= SERIAL_DEF;
    end else if (srst_r) begin
      serial_port_select_r <= SERIAL_DEF;
    end else if (REG_WR_I && (REG_ADDR_I == ADDR_SERIAL)) begin
      serial_port_select_r <= REG_WDATA_I & SERIAL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL lock arrives from the analog side; two stages must agree
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pll_s1_r <= 1'b0;
      pll_s2_r <= 1'b0;
      pll_s3_r <= 1'b0;
      pll_ok_r <= 1'b0;
    end else begin
      pll_s1_r <= PLL_READY_I;
      pll_s2_r <= pll_s1_r;
      pll_s3_r <= pll_s2_r;
      if (pll_s2_r == pll_s3_r) begin
        pll_ok_r <= pll_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency
  always_comb begin
    case (REG_ADDR_I)
      ADDR_PWR_MAIN: rd_mux = {srst_r, power_control_main_r[BIT_HALT:0]};
      ADDR_AXIS:     rd_mux = axis_standby_control_r;
      ADDR_SERIAL:   rd_mux = serial_port_select_r;
      ADDR_FILL_HI:  rd_mux = fill_held[FILL_W-1:DATA_W];
      ADDR_FILL_LO:  rd_mux = fill_held[DATA_W-1:0];
      default:       rd_mux = RDATA_NONE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O  <= RDATA_NONE;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_mux;
      end
    end
  end

  pmfc_fill_latch u_fill (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .clr_i   (srst_r),
    .live_i  (FILL_COUNT_I),
    .rd_hi_i (rd_hi),
    .rd_lo_i (rd_lo),
    .held_o  (fill_held),
    .armed_o (fill_armed)
  );

  pmfc_duty_timer #(
    .BASE_CYC (WAKE_BASE_CYC)
  ) u_duty (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .run_i       (cycle_run),
    .div_i       (SAMPLE_RATE_DIVIDER_I),
    .accel_any_i (~&accel_off),
    .wake_o      (WAKE_O),
    .sample_o    (ACCEL_SAMPLE_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Power and clock controls; gyro is off while duty cycling
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SOFT_RESET_BUSY_O     <= 1'b0;
      DEVICE_SLEEP_O        <= 1'b0;
      ACCEL_AXIS_EN_O       <= '0;
      RATE_SENSE_EN_O       <= '0;
      GYRO_DRIVE_EN_O       <= 1'b0;
      PLL_EN_O              <= 1'b0;
      THERMAL_SENSOR_EN_O   <= 1'b0;
      CLK_USE_OSC_O         <= 1'b1;
      CLK_USE_PLL_O         <= 1'b0;
      CLK_STOP_O            <= 1'b0;
      TIMING_RESET_O        <= 1'b1;
      TWO_WIRE_TARGET_OFF_O <= 1'b0;
    end else begin
      SOFT_RESET_BUSY_O <= srst_r;
      DEVICE_SLEEP_O <= halt || (cycle_run && !WAKE_O);
      ACCEL_AXIS_EN_O <= {AXIS_W{!halt && !clk_halted}} & ~accel_off;
      RATE_SENSE_EN_O <= {AXIS_W{!halt && !gyro_stby && !cycle_run &&
                                 !clk_halted}} & ~rate_off;
      GYRO_DRIVE_EN_O <= !halt && !cycle_run && !clk_halted &&
                         (gyro_stby || !(&rate_off));
      PLL_EN_O        <= !halt && !cycle_run && !clk_halted &&
                         (gyro_stby || !(&rate_off));
      THERMAL_SENSOR_EN_O <= !halt && !clk_halted &&
                             !power_control_main_r[BIT_THERM_OFF];
      CLK_USE_OSC_O <= clk_is_osc(clock_source_select) ||
                       (clk_is_auto(clock_source_select) && !pll_ok_r);
      CLK_USE_PLL_O <= clk_is_auto(clock_source_select) && pll_ok_r;
      CLK_STOP_O     <= clk_halted;
      TIMING_RESET_O <= clk_halted || srst_r;
      TWO_WIRE_TARGET_OFF_O <= serial_port_select_r[BIT_TWO_WIRE_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_soft_reset_len: assert property (
    $fell(srst_r) |-> $past(srst_cnt_r) == SRST_LAST &&
                      power_control_main_r == PWR_MAIN_DEF)
    else $error("soft reset length or default wrong");
  a_clock_source_select_default: assert property (
    $fell(srst_r) |-> clock_source_select == CLOCK_SOURCE_SELECT_DEF)
    else $error("clock source not default after soft reset");
  a_halt_sleeps: assert property (
    halt |=> DEVICE_SLEEP_O && RATE_SENSE_EN_O == '0)
    else $error("halt did not sleep");
  a_sample_needs_axis: assert property (
    ACCEL_SAMPLE_O |-> WAKE_O && $past(!(&accel_off)))
    else $error("sample without enabled axis");
  a_wake_gated: assert property (
    WAKE_O |-> $past(power_control_main_r[BIT_CYCLE] && !halt &&
                     !gyro_stby))
    else $error("wake outside duty cycling");
  a_gyro_standby: assert property (
    gyro_stby && !halt && !clk_halted |=>
      GYRO_DRIVE_EN_O && PLL_EN_O && RATE_SENSE_EN_O == '0)
    else $error("gyro standby controls wrong");
  a_thermal_off: assert property (
    power_control_main_r[BIT_THERM_OFF] |=> !THERMAL_SENSOR_EN_O)
    else $error("temperature sensor not off");
  a_clk_osc: assert property (
    clk_is_osc(clock_source_select) |=> CLK_USE_OSC_O && !CLK_USE_PLL_O)
    else $error("oscillator not selected");
  a_clk_auto: assert property (
    clk_is_auto(clock_source_select) |=> CLK_USE_PLL_O == $past(pll_ok_r)
                                      && CLK_USE_OSC_O == !$past(pll_ok_r))
    else $error("auto clock choice wrong");
  a_clk_stop: assert property (
    clk_halted |=> CLK_STOP_O && TIMING_RESET_O && !CLK_USE_PLL_O)
    else $error("clock stop not applied");
  a_axis_enables: assert property (
    !halt && !clk_halted |=> ACCEL_AXIS_EN_O == ~$past(accel_off))
    else $error("accelerometer axis enable wrong");
  a_rate_enables: assert property (
    !halt && !gyro_stby && !cycle_run && !clk_halted |=>
      RATE_SENSE_EN_O == ~$past(rate_off))
    else $error("gyro sense enable wrong");
  a_two_wire_off: assert property (
    serial_port_select_r[BIT_TWO_WIRE_OFF] |=> TWO_WIRE_TARGET_OFF_O)
    else $error("two-wire target not off");
  a_fill_snapshot: assert property (
    rd_hi && fill_armed ##1 (!rd_lo && !srst_r)[*2] |->
      fill_held == $past(fill_held, 2))
    else $error("fill snapshot moved before low read");
  a_reserved_zero: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_SERIAL |=>
      (REG_RDATA_O & ~SERIAL_MASK) == RDATA_NONE)
    else $error("reserved bits not zero");

  c_soft_reset: cover property ($fell(srst_r));
  c_duty_sample: cover property (ACCEL_SAMPLE_O);
  c_wake_no_sample: cover property (WAKE_O && !ACCEL_SAMPLE_O);
  c_fill_pair: cover property (rd_hi && fill_armed ##[1:8] rd_lo);

endmodule : pmfc_regs

// ### bench/pmfc_host.sv
// Host model for the strobe register port
`timescale 1ns/1ps
module pmfc_host
  import pmfc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              rvalid_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   wr_o,
  output logic                   rd_o,
  output logic      [DATA_W-1:0] wdata_o
);
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle address and data are scrambled so nothing relies on stale values
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [8:0] q);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    q = {rvalid_i, rdata_i};
  endtask : rd
endmodule : pmfc_host

// ### bench/tb.sv
// Self-checking bench for the power and fill-count register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import pmfc_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              pll = 1'b0;
  logic [FILL_W-1:0] fill = '0;
  logic [DATA_W-1:0] div = 8'h02;
  wire  [ADDR_W-1:0] addr;
  wire  [DATA_W-1:0] wdata, rdata;
  wire               wr, rd, rvalid, busy, sleep, wake, samp;
  wire  [AXIS_W-1:0] acc_en, rate_en;
  wire               drive, pll_en, therm, osc, upll, stop, trst, twoff;
  int                bad_count = 0;
  int                compares = 0;
  int                n;
  logic [DATA_W-1:0] d;
  logic [FILL_W-1:0] v;
  logic [8:0]        q;

  pmfc_regs #(.WAKE_BASE_CYC(4)) pmfc_regs_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .FILL_COUNT_I(fill),
    .SAMPLE_RATE_DIVIDER_I(div), .PLL_READY_I(pll), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .SOFT_RESET_BUSY_O(busy), .DEVICE_SLEEP_O(sleep),
    .WAKE_O(wake), .ACCEL_SAMPLE_O(samp), .ACCEL_AXIS_EN_O(acc_en),
    .RATE_SENSE_EN_O(rate_en), .GYRO_DRIVE_EN_O(drive), .PLL_EN_O(pll_en),
    .THERMAL_SENSOR_EN_O(therm), .CLK_USE_OSC_O(osc), .CLK_USE_PLL_O(upll),
    .CLK_STOP_O(stop), .TIMING_RESET_O(trst), .TWO_WIRE_TARGET_OFF_O(twoff));

  pmfc_host pmfc_host_inst (
    .clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  initial forever #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] clk_exp(input logic [2:0] c, input logic p);
    if (c == 3'h7) return 3'b001;
    if (c == 3'h0 || c == 3'h6) return 3'b100;
    return p ? 3'b010 : 3'b100;
  endfunction : clk_exp

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    pmfc_host_inst.rd(a, q);
    `CHK(q, {1'b1, e})
  endtask : rdchk

  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic next_wake(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (wake !== 1'b1 && k < 300);
  endtask : next_wake

  task automatic results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Whole run is well under a thousand cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    d = 8'($urandom(3617));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    rdchk(ADDR_PWR_MAIN, 8'h01);
    rdchk(ADDR_AXIS, 8'h00);
    `CHK(osc, 1'b1)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      pmfc_host_inst.wr(ADDR_AXIS, d);
      pmfc_host_inst.wr(ADDR_SERIAL, d);
      pmfc_host_inst.wr(7'h71, d);
      settle();
      rdchk(ADDR_AXIS, d & 8'h3f);
      rdchk(ADDR_SERIAL, d & 8'h40);
      rdchk(7'h71, 8'h00);
      `CHK(acc_en, ~d[5:3])
      `CHK(rate_en, ~d[2:0])
      `CHK(twoff, d[6])
    end
    pmfc_host_inst.wr(ADDR_AXIS, 8'h00);
    $display("test fields done");
    @(posedge clk);
    pll <= 1'b1;
    // Last pass repeats code 1 with the PLL unlocked
    for (int c = 0; c < 9; c++) begin
      d = (c == 8) ? 8'h01 : 8'(c);
      if (c == 8) begin
        @(posedge clk);
        pll <= 1'b0;
      end
      pmfc_host_inst.wr(ADDR_PWR_MAIN, d);
      repeat (6) settle();
      rdchk(ADDR_PWR_MAIN, d);
      `CHK({osc, upll, stop}, clk_exp(d[2:0], c < 8))
      `CHK(trst, c == 7)
    end
    $display("test clock done");
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h41);
    settle();
    `CHK(sleep, 1'b1)
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h09);
    settle();
    `CHK({sleep, therm}, 2'b00)
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h11);
    settle();
    `CHK({drive, pll_en, rate_en}, 5'b11000)
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h01);
    settle();
    `CHK({therm, drive}, 2'b11)
    $display("test modes done");
    @(posedge clk);
    div <= 8'($urandom % 4);
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h21);
    next_wake(n);
    `CHK(samp, 1'b1)
    next_wake(n);
    `CHK(n, (div + 1) * 4)
    pmfc_host_inst.wr(ADDR_AXIS, 8'h38);
    next_wake(n);
    next_wake(n);
    `CHK({wake, samp}, 2'b10)
    `CHK(n, (div + 1) * 4)
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h01);
    $display("test duty done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0400 : 16'($urandom);
      @(posedge clk);
      fill <= v;
      settle();
      rdchk(ADDR_FILL_HI, v[15:8]);
      @(posedge clk);
      fill <= ~v;
      settle();
      rdchk(ADDR_FILL_HI, v[15:8]);
      rdchk(ADDR_FILL_LO, v[7:0]);
      settle();
      rdchk(ADDR_FILL_HI, ~v[15:8]);
      rdchk(ADDR_FILL_LO, ~v[7:0]);
    end
    $display("test count done");
    pmfc_host_inst.wr(ADDR_AXIS, 8'h2a);
    pmfc_host_inst.wr(ADDR_SERIAL, 8'h40);
    pmfc_host_inst.wr(ADDR_PWR_MAIN, 8'h80);
    n = 0;
    while (busy !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    `CHK(busy, 1'b1)
    // Reset bit reads one while busy; writes meanwhile are dropped
    rdchk(ADDR_PWR_MAIN, 8'h81);
    pmfc_host_inst.wr(ADDR_AXIS, 8'h07);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
    rdchk(ADDR_PWR_MAIN, 8'h01);
    rdchk(ADDR_AXIS, 8'h00);
    rdchk(ADDR_SERIAL, 8'h00);
    $display("test soft reset done");
    results();
  end
endmodule : tb
